// [adc_seq_consts.svh]
// Purpose: Offsets, field positions, reset values and counts of the
//          converter sequencer.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

`define ADDR_W        12
`define OFF_CTRL      12'h000
`define OFF_SEQ       12'h004
`define OFF_DIFF      12'h008
`define OFF_INJ       12'h00C
`define OFF_DATA      12'h010
`define OFF_JDATA     12'h014
`define OFF_STATUS    12'h018
`define OFF_IE        12'h01C
`define OFF_CLR       12'h020
`define OFF_AWD_THR   12'h024
`define OFF_AWD_MASK  12'h030
`define AWD_STRIDE    12'h004

`define CTRL_RES_LSB  0
`define CTRL_RES_MSB  3
`define CTRL_SCAN     4
`define CTRL_DMA      5
`define CTRL_TSEL_LSB 6
`define CTRL_TSEL_MSB 7
`define CTRL_INJ_EN   8
`define CTRL_SIMUL    9
`define CTRL_START    10
`define CTRL_EN       11
`define CTRL_W        12
`define CTRL_RST      12'h00C

`define ST_EOC        0
`define ST_EOS        1
`define ST_JEOC       2
`define ST_AWD0       3
`define ST_W          6

`define RES_MAX       4'hC
`define RES_MIN       4'h6
`define MSB_IDX       4'hB
`define CODE_MSB      12'h800
`define THR_HI_LSB    16
`define N_CH          19
`define N_AWD         3
`define CH_W          5
`define CH_TEMP       5'h10
`define CH_VBAT       5'h11
`define CH_VREF       5'h12
`define CH_NONE       5'h1F
`define CH_UNUSED     5'h0F
`define SMP_TIME_NS   40
`define CLK_PERIOD_NS 10

`endif

// [adc_seq_pkg.sv]
// Purpose: Types shared by the converter sequencer.
// Assumes: adc_seq_consts.svh for widths.
// Notes:   State of the top module is one packed struct.
`include "adc_seq_consts.svh"

package adc_seq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b10,
    ST_DONE   = 2'b11
  } seq_state_type;

  typedef struct packed {
    logic                    sample;
    logic [`N_CH-1:0]        track_mask;
    logic [`CH_W-1:0]        ch;
    logic                    diff;
    logic [11:0]             dac_code;
    logic                    temp_en;
    logic                    vbat_div_en;
    logic                    vref_en;
  } afe_ctrl_type;

  typedef struct packed {
    seq_state_type           state;
    logic [`CTRL_W-1:0]      ctrl;
    logic [`N_CH-1:0]        seq;
    logic [`N_CH-1:0]        diff;
    logic [`CH_W-1:0]        inj;
    logic [11:0]             data;
    logic [11:0]             jdata;
    logic [`ST_W-1:0]        status;
    logic [`ST_W-1:0]        ie;
    logic [`N_AWD-1:0][11:0] awd_lo;
    logic [`N_AWD-1:0][11:0] awd_hi;
    logic [`N_AWD-1:0][`N_CH-1:0] awd_mask;
    logic [`CH_W-1:0]        ch;
    logic [11:0]             code;
    logic [3:0]              bit_idx;
    logic [7:0]              cnt;
    logic                    inj_active;
    logic                    first;
    logic                    reg_pend;
    logic                    inj_pend;
    logic                    dma_pend;
    logic                    ack;
    logic                    slverr;
    logic [31:0]             prdata;
  } seq_regs_type;

endpackage

// [adc_sequencer_control.sv]
// Purpose: Digital control of a SAR converter: sequencing, SAR search,
//          watchdogs, DMA request and APB register file.
// Assumes: comp_i is the comparator, high when input >= dac_code.
// Notes:
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

module adc_sequencer_control
  import adc_seq_pkg::*;
#(
  parameter int SMP_CYCLES = (`SMP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // Clock, reset, enable
  input  wire logic               core_clk_i,
  input  wire logic               arst_n_i,
  input  wire logic               ce_i,
  // APB slave
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [`ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic [31:0]             prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  // Triggers
  input  wire logic [2:0]         general_timers_trig_i,
  input  wire logic               advanced_timer_trig_i,
  // Analog front end
  input  wire logic               comp_i,
  output afe_ctrl_type            afe_o,
  // DMA and interrupt
  output logic                    dma_req_o,
  input  wire logic               dma_ack_i,
  output logic                    irq_o
);

  localparam logic [7:0] SMP_LAST = 8'(SMP_CYCLES - 1);

  seq_regs_type r_reg;
  seq_regs_type r_next;

  function automatic logic [3:0] res_eff(input logic [3:0] res);
    if (res < `RES_MIN) begin
      return `RES_MIN;
    end
    if (res > `RES_MAX) begin
      return `RES_MAX;
    end
    return res;
  endfunction

  // Lowest set channel at or above start; CH_NONE if none
  function automatic logic [`CH_W-1:0] first_from(input logic [`N_CH-1:0] m,
                                                 input logic [`CH_W-1:0] start);
    logic [`CH_W-1:0] f;
    f = `CH_NONE;
    for (int i = `N_CH - 1; i >= 0; i--) begin
      if (m[i] && (i >= int'(start))) begin
        f = `CH_W'(i);
      end
    end
    return f;
  endfunction

  function automatic logic [`N_CH-1:0] onehot(input logic [`CH_W-1:0] c);
    return `N_CH'(1) << c;
  endfunction

  // Channels that an injected conversion may select; code 15 has no input behind it
  function automatic logic ch_valid(input logic [`CH_W-1:0] c);
    if (c == `CH_UNUSED) begin
      return 1'b0;
    end
    return (c < `CH_W'(`N_CH));
  endfunction

  // Watchdog window test on the right-aligned result
  function automatic logic out_of_window(input logic [11:0] v,
                                         input logic [11:0] lo,
                                         input logic [11:0] hi);
    return (v < lo) || (v > hi);
  endfunction

  logic             acc;
  logic             wr;
  logic             hit;
  logic [31:0]      rd_mux;
  logic [`ST_W-1:0] ev;
  logic [`ST_W-1:0] clr;
  logic [3:0]       lsb;
  logic [11:0]      result;
  logic             reg_trig;
  logic [1:0]       tsel;
  logic [`CH_W-1:0] nxt;

  // Out-of-range resolution codes clamp to the nearest legal width
  assign lsb  = `RES_MAX - res_eff(r_reg.ctrl[`CTRL_RES_MSB:`CTRL_RES_LSB]);
  assign tsel = r_reg.ctrl[`CTRL_TSEL_MSB:`CTRL_TSEL_LSB];

  // Register read decode
  // Unmapped offsets answer with pslverr and read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    hit    = 1'b1;
    unique case (paddr_i)
      `OFF_CTRL:   rd_mux = 32'(r_reg.ctrl);
      `OFF_SEQ:    rd_mux = 32'(r_reg.seq);
      `OFF_DIFF:   rd_mux = 32'(r_reg.diff);
      `OFF_INJ:    rd_mux = 32'(r_reg.inj);
      `OFF_DATA:   rd_mux = 32'(r_reg.data);
      `OFF_JDATA:  rd_mux = 32'(r_reg.jdata);
      `OFF_STATUS: rd_mux = 32'(r_reg.status);
      `OFF_IE:     rd_mux = 32'(r_reg.ie);
      `OFF_CLR:    rd_mux = 32'h0000_0000;
      default: begin
        hit = 1'b0;
        for (int i = 0; i < `N_AWD; i++) begin
          if (paddr_i == `OFF_AWD_THR + `AWD_STRIDE * `ADDR_W'(i)) begin
            hit    = 1'b1;
            rd_mux = {4'h0, r_reg.awd_hi[i], 4'h0, r_reg.awd_lo[i]};
          end
          if (paddr_i == `OFF_AWD_MASK + `AWD_STRIDE * `ADDR_W'(i)) begin
            hit    = 1'b1;
            rd_mux = 32'(r_reg.awd_mask[i]);
          end
        end
      end
    endcase
  end

  always_comb begin
    r_next = r_reg;
    acc    = psel_i && penable_i;
    // Write lands on the edge where pready is seen high
    wr     = acc && r_reg.ack && pwrite_i && !r_reg.slverr;
    ev     = '0;
    clr    = '0;
    result = r_reg.code >> lsb;
    nxt    = `CH_NONE;

    // One wait state keeps prdata a flop output
    r_next.ack = 1'b0;
    if (acc && !r_reg.ack) begin
      r_next.ack    = 1'b1;
      r_next.prdata = rd_mux;
      r_next.slverr = !hit;
    end

    if (wr) begin
      // Start reads back zero; it only arms a pending request
      unique case (paddr_i)
        `OFF_CTRL: r_next.ctrl = pwdata_i[`CTRL_W-1:0] & ~(`CTRL_W'(1) << `CTRL_START);
        `OFF_SEQ:  r_next.seq  = pwdata_i[`N_CH-1:0];
        `OFF_DIFF: r_next.diff = pwdata_i[`N_CH-1:0];
        `OFF_INJ:  r_next.inj  = pwdata_i[`CH_W-1:0];
        `OFF_IE:   r_next.ie   = pwdata_i[`ST_W-1:0];
        `OFF_CLR:  clr         = pwdata_i[`ST_W-1:0];
        default: begin
          for (int i = 0; i < `N_AWD; i++) begin
            if (paddr_i == `OFF_AWD_THR + `AWD_STRIDE * `ADDR_W'(i)) begin
              r_next.awd_lo[i] = pwdata_i[11:0];
              r_next.awd_hi[i] = pwdata_i[`THR_HI_LSB +: 12];
            end
            if (paddr_i == `OFF_AWD_MASK + `AWD_STRIDE * `ADDR_W'(i)) begin
              r_next.awd_mask[i] = pwdata_i[`N_CH-1:0];
            end
          end
        end
      endcase
    end

    // Trigger capture
    // Triggers while busy wait as one pending request each
    reg_trig = wr && (paddr_i == `OFF_CTRL) && pwdata_i[`CTRL_START];
    if (tsel != 2'b00) begin
      reg_trig = reg_trig || general_timers_trig_i[tsel - 2'b01];
    end
    if (reg_trig) begin
      r_next.reg_pend = 1'b1;
    end
    if (advanced_timer_trig_i && r_reg.ctrl[`CTRL_INJ_EN]) begin
      r_next.inj_pend = 1'b1;
    end

    unique case (r_reg.state)
      ST_IDLE: begin
        r_next.cnt = 8'h00;
        if (r_reg.ctrl[`CTRL_EN]) begin
          if (r_reg.inj_pend) begin
            // Injected goes first so shunt sampling stays near its edge
            r_next.inj_pend   = 1'b0;
            // A start on an unwired channel code is dropped
            if (ch_valid(r_reg.inj)) begin
              r_next.inj_active = 1'b1;
              r_next.ch         = r_reg.inj;
              r_next.first      = 1'b1;
              r_next.state      = ST_SAMPLE;
            end
          end else if (r_reg.reg_pend) begin
            // Start with an empty sequence is dropped
            r_next.reg_pend   = 1'b0;
            nxt               = first_from(r_reg.seq, '0);
            if (nxt != `CH_NONE) begin
              r_next.inj_active = 1'b0;
              r_next.ch         = nxt;
              r_next.first      = 1'b1;
              r_next.state      = ST_SAMPLE;
            end
          end
        end
      end
      ST_SAMPLE: begin
        // Window long enough for the hold capacitor to settle
        r_next.cnt = r_reg.cnt + 8'h01;
        if (r_reg.cnt >= SMP_LAST) begin
          r_next.cnt     = 8'h00;
          r_next.code    = `CODE_MSB;
          r_next.bit_idx = `MSB_IDX;
          r_next.state   = ST_CONV;
        end
      end
      ST_CONV: begin
        // One comparator decision per cycle, MSB first
        if (!comp_i) begin
          r_next.code[r_reg.bit_idx] = 1'b0;
        end
        // Resolution written mid-conversion must not run past bit 0
        if (r_reg.bit_idx <= lsb) begin
          r_next.state = ST_DONE;
        end else begin
          r_next.bit_idx = r_reg.bit_idx - 4'h1;
          r_next.code[r_reg.bit_idx - 4'h1] = 1'b1;
        end
      end
      ST_DONE: begin
        // Watchdogs look at every result, injected ones too
        for (int i = 0; i < `N_AWD; i++) begin
          if (r_reg.awd_mask[i][r_reg.ch] &&
              out_of_window(result, r_reg.awd_lo[i], r_reg.awd_hi[i])) begin
            ev[`ST_AWD0 + i] = 1'b1;
          end
        end
        r_next.state = ST_IDLE;
        r_next.first = 1'b0;
        if (r_reg.inj_active) begin
          r_next.jdata       = result;
          ev[`ST_JEOC]       = 1'b1;
          r_next.inj_active  = 1'b0;
        end else begin
          r_next.data        = result;
          ev[`ST_EOC]        = 1'b1;
          if (r_reg.ctrl[`CTRL_DMA]) begin
            r_next.dma_pend  = 1'b1;
          end
          if (r_reg.ctrl[`CTRL_SCAN] && r_reg.ch != `CH_NONE) begin
            nxt = first_from(r_reg.seq, r_reg.ch + `CH_W'(1));
          end
          if (nxt != `CH_NONE) begin
            r_next.ch = nxt;
            // Simultaneous mode converts held values, no new sample
            if (r_reg.ctrl[`CTRL_SIMUL]) begin
              r_next.code    = `CODE_MSB;
              r_next.bit_idx = `MSB_IDX;
              r_next.state   = ST_CONV;
            end else begin
              r_next.state   = ST_SAMPLE;
            end
          end else begin
            ev[`ST_EOS] = 1'b1;
          end
        end
      end
    endcase

    // DMA ack clears unless a new regular result lands the same cycle
    if (dma_ack_i && !(r_reg.state == ST_DONE && !r_reg.inj_active)) begin
      r_next.dma_pend = 1'b0;
    end
    // Set wins over clear
    r_next.status = (r_reg.status & ~clr) | ev;
    // Enable as it will stand, so one write of enable and start keeps the start
    if (!r_next.ctrl[`CTRL_EN]) begin
      r_next.reg_pend = 1'b0;
      r_next.inj_pend = 1'b0;
    end
  end

  // Clock enable low freezes every flop, APB answer included
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_reg          <= '0;
      r_reg.state    <= ST_IDLE;
      r_reg.ctrl     <= `CTRL_RST;
      // Channel code that selects no input until the first conversion starts
      r_reg.ch       <= `CH_NONE;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  // Front-end controls decode from flops, so no glitch reaches a switch
  always_comb begin
    afe_o             = '0;
    afe_o.sample      = (r_reg.state == ST_SAMPLE);
    afe_o.ch          = r_reg.ch;
    afe_o.diff        = ch_valid(r_reg.ch) ? r_reg.diff[r_reg.ch] : 1'b0;
    afe_o.dac_code    = r_reg.code;
    afe_o.temp_en     = (r_reg.ch == `CH_TEMP);
    afe_o.vbat_div_en = (r_reg.ch == `CH_VBAT);
    afe_o.vref_en     = (r_reg.ch == `CH_VREF);
    if (r_reg.state == ST_SAMPLE) begin
      if (r_reg.ctrl[`CTRL_SIMUL] && r_reg.first && !r_reg.inj_active) begin
        afe_o.track_mask = r_reg.seq;
      end else begin
        afe_o.track_mask = onehot(r_reg.ch);
      end
    end
  end

  assign prdata_o  = r_reg.prdata;
  assign pready_o  = r_reg.ack;
  assign pslverr_o = r_reg.ack && r_reg.slverr;
  assign dma_req_o = r_reg.dma_pend;
  // Level interrupt, held until status is cleared or masked
  assign irq_o     = |(r_reg.status & r_reg.ie);

endmodule

// [adc_seq_asserts.sv]
// Purpose: Port-level checks of the converter sequencer.
// Assumes: ce_i high whenever the APB is used.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

module adc_seq_asserts
  import adc_seq_pkg::*;
#(
  parameter int SMP_CYCLES = 4
) (
  // Clock and reset
  input wire logic         core_clk_i,
  input wire logic         arst_n_i,
  input wire logic         ce_i,
  // APB
  input wire logic         psel_i,
  input wire logic         penable_i,
  input wire logic         pready_o,
  input wire logic         pslverr_o,
  // Front end and DMA
  input wire afe_ctrl_type afe_o,
  input wire logic         dma_req_o,
  input wire logic         dma_ack_i
);
  logic [7:0] run_reg;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  // Length of the last sample phase
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) run_reg <= 8'h00;
    else if (ce_i) run_reg <= afe_o.sample ? run_reg + 8'h01 : 8'h00;
  end

  ready_answers_a: assert property (psel_i && penable_i && !pready_o && ce_i |=> pready_o)
    else $error("pready late");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("pready without access");
  slverr_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("pslverr outside answer");
  sample_len_a: assert property ($fell(afe_o.sample) |-> run_reg == 8'(SMP_CYCLES))
    else $error("sample phase length wrong");
  track_sample_a: assert property (|afe_o.track_mask |-> afe_o.sample)
    else $error("track mask outside sample");
  no_ch15_a: assert property (afe_o.ch != `CH_UNUSED)
    else $error("unused channel code selected");
  temp_route_a: assert property (afe_o.temp_en |-> afe_o.ch == `CH_TEMP)
    else $error("temperature sensor on wrong channel");
  vbat_route_a: assert property (afe_o.vbat_div_en |-> afe_o.ch == `CH_VBAT)
    else $error("battery divider on wrong channel");
  vref_route_a: assert property (afe_o.vref_en |-> afe_o.ch == `CH_VREF)
    else $error("reference on wrong channel");
  dma_clear_a: assert property (dma_ack_i && dma_req_o |=> !dma_req_o)
    else $error("dma request not cleared by ack");
endmodule

bind adc_sequencer_control adc_seq_asserts #(.SMP_CYCLES(SMP_CYCLES)) adc_seq_asserts_inst (
  .core_clk_i, .arst_n_i, .ce_i, .psel_i, .penable_i, .pready_o, .pslverr_o,
  .afe_o, .dma_req_o, .dma_ack_i);

// [adc_afe_model.sv]
// Purpose: Analog inputs and comparator seen by the sequencer.
// Assumes: Fixed level per channel, comparator ideal.
// Notes:   Temperature and reference read zero unless their switch is on; the battery reads undivided unless its divider is on.
`timescale 1ns/1ps

module adc_afe_model
  import adc_seq_pkg::*;
(
  // Front end control
  input  wire afe_ctrl_type afe_i,
  // Comparator
  output logic              comp_o
);
  logic [11:0] level;

  always_comb begin
    case (afe_i.ch)
      5'h10:   level = afe_i.temp_en ? 12'h7C3 : 12'h000;
      5'h11:   level = afe_i.vbat_div_en ? 12'h720 : 12'hE40;
      5'h12:   level = afe_i.vref_en ? 12'h5F0 : 12'h000;
      // Differential pair reads a distinct level
      default: level = {afe_i.ch[3:0], afe_i.diff ? 8'hA5 : 8'h5A};
    endcase
    comp_o = level >= afe_i.dac_code;
  end
endmodule

// [tb_adc_sequencer_control.sv]
// Purpose: Self-checking bench of the converter sequencer.
// Assumes: SMP_CYCLES 4, ce_i held high.
// Notes:   Registers reached through an APB master task.
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

module tb_adc_sequencer_control;
  import adc_seq_pkg::*;
  logic               core_clk_i = 1'b0;
  logic               arst_n_i = 1'b0;
  logic               psel_i = 1'b0;
  logic               penable_i = 1'b0;
  logic               pwrite_i = 1'b0;
  logic [`ADDR_W-1:0] paddr_i = 12'h000;
  logic [31:0]        pwdata_i = 32'h0000_0000;
  logic [31:0]        prdata_o;
  logic               pready_o;
  logic               pslverr_o;
  logic [2:0]         general_timers_trig_i = 3'h0;
  logic               advanced_timer_trig_i = 1'b0;
  logic               comp_i;
  afe_ctrl_type       afe_o;
  logic               dma_req_o;
  logic               dma_ack_i = 1'b0;
  logic               irq_o;
  logic [31:0]        rd;
  logic               er;
  int                 err_count = 0;
  int                 checks_done = 0;

  always #5 core_clk_i = ~core_clk_i;

  adc_sequencer_control #(.SMP_CYCLES(4)) adc_sequencer_control_inst (
    .core_clk_i, .arst_n_i, .ce_i(1'b1), .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .general_timers_trig_i,
    .advanced_timer_trig_i, .comp_i, .afe_o, .dma_req_o, .dma_ack_i, .irq_o);
  adc_afe_model adc_afe_model_inst (.afe_i(afe_o), .comp_o(comp_i));

  function automatic logic [11:0] lvl(input logic [4:0] c, input logic d);
    if (c == 5'h10) return 12'h7C3;
    if (c == 5'h11) return 12'h720;
    if (c == 5'h12) return 12'h5F0;
    return {c[3:0], d ? 8'hA5 : 8'h5A};
  endfunction

  task automatic stop_test;
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic wait_st(input logic [31:0] m);
    int i;
    rd = 32'h0000_0000;
    for (i = 0; i < 100 && (rd & m) !== m; i++) apb(1'b0, `OFF_STATUS, 32'h0000_0000);
    chk("status", m, rd & m);
  endtask

  task automatic chk_irq(input logic e);
    repeat (2) @(posedge core_clk_i);
    chk("irq", {31'h0000_0000, e}, {31'h0000_0000, irq_o});
  endtask

  task automatic pulse(input logic [2:0] g, input logic a);
    general_timers_trig_i <= g;
    advanced_timer_trig_i <= a;
    @(posedge core_clk_i);
    general_timers_trig_i <= 3'h0;
    advanced_timer_trig_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic t_reset;
    apb(1'b0, `OFF_CTRL, 32'h0000_0000);
    chk("ctrl", 32'h0000_000C, rd);
    apb(1'b0, 12'h3FC, 32'h0000_0000);
    chk("bad_err", 32'h0000_0001, {31'h0000_0000, er});
    chk("bad_data", 32'h0000_0000, rd);
    chk_irq(1'b0);
  endtask

  task automatic t_single;
    logic [3:0] r;
    apb(1'b1, `OFF_SEQ, 32'h0000_0028);
    for (r = 4'h6; r <= 4'hC; r += 4'h3) begin
      apb(1'b1, `OFF_CLR, 32'h0000_003F);
      apb(1'b1, `OFF_CTRL, 32'h0000_0C00 | r);
      wait_st(32'h0000_0003);
      apb(1'b0, `OFF_DATA, 32'h0000_0000);
      chk("data", lvl(5'h03, 1'b0) >> (4'hC - r), rd);
    end
  endtask

  task automatic t_scan;
    logic [4:0] chs [5] = '{5'h01, 5'h02, 5'h10, 5'h11, 5'h12};
    int i;
    int k;
    apb(1'b1, `OFF_CLR, 32'h0000_003F);
    apb(1'b1, `OFF_DIFF, 32'h0000_0002);
    apb(1'b1, `OFF_SEQ, 32'h0007_0006);
    apb(1'b1, `OFF_CTRL, 32'h0000_0E3C);
    for (i = 0; i < 50 && afe_o.sample !== 1'b1; i++) @(posedge core_clk_i);
    chk("track", 32'h0007_0006, {13'h0000, afe_o.track_mask});
    for (k = 0; k < 5; k++) begin
      for (i = 0; i < 100 && dma_req_o !== 1'b1; i++) @(posedge core_clk_i);
      apb(1'b0, `OFF_DATA, 32'h0000_0000);
      chk("scan_data", lvl(chs[k], k == 0), rd);
      dma_ack_i <= 1'b1;
      @(posedge core_clk_i);
      dma_ack_i <= 1'b0;
      @(posedge core_clk_i);
    end
    wait_st(32'h0000_0003);
  endtask

  task automatic t_awd;
    apb(1'b1, `OFF_CLR, 32'h0000_003F);
    apb(1'b1, `OFF_AWD_THR, 32'h0200_0100);
    apb(1'b1, `OFF_AWD_MASK, 32'h0000_0008);
    apb(1'b1, `OFF_IE, 32'h0000_0008);
    apb(1'b1, `OFF_SEQ, 32'h0000_0008);
    apb(1'b1, `OFF_CTRL, 32'h0000_0C0C);
    wait_st(32'h0000_0009);
    chk_irq(1'b1);
    apb(1'b1, `OFF_IE, 32'h0000_0000);
    chk_irq(1'b0);
    apb(1'b1, `OFF_IE, 32'h0000_0008);
    chk_irq(1'b1);
    apb(1'b1, `OFF_CLR, 32'h0000_0008);
    chk_irq(1'b0);
  endtask

  task automatic t_trig;
    apb(1'b1, `OFF_CLR, 32'h0000_003F);
    apb(1'b1, `OFF_CTRL, 32'h0000_088C);
    pulse(3'h1, 1'b0);
    repeat (40) @(posedge core_clk_i);
    apb(1'b0, `OFF_STATUS, 32'h0000_0000);
    chk("wrong_trig", 32'h0000_0000, rd & 32'h0000_0003);
    pulse(3'h2, 1'b0);
    wait_st(32'h0000_0001);
    apb(1'b1, `OFF_INJ, 32'h0000_0005);
    apb(1'b1, `OFF_CTRL, 32'h0000_090C);
    pulse(3'h0, 1'b1);
    wait_st(32'h0000_0004);
    apb(1'b0, `OFF_JDATA, 32'h0000_0000);
    chk("jdata", lvl(5'h05, 1'b0), rd);
  endtask

  initial begin
    #200000;
    err_count++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    @(posedge core_clk_i);
    t_reset();
    t_single();
    t_scan();
    t_awd();
    t_trig();
    stop_test();
  end
endmodule
